// ===== hdl/clkrun_pkg.sv
// Constants shared by the clock run keeper and the host controller end.
// Assumes a single bus clock domain of 40 MHz for both ends.
package clkrun_pkg;

  // ==========================================================================
  // Shift register and line levels
  localparam int   KEEP_STAGES   = 2;
  localparam logic LINE_ASSERTED = 1'b0;
  localparam logic LINE_NEGATED  = 1'b1;
  localparam logic OE_DRIVE      = 1'b0;
  localparam logic OE_RELEASE    = 1'b1;

  // ==========================================================================
  // Host side timing, counted in bus clocks
  localparam int CLK_PERIOD_NS   = 25;
  localparam int STOP_WAIT_NS    = 125;
  localparam int STOP_WAIT_CYC   = (STOP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_CNT_W      = 4;
  localparam logic [STOP_CNT_W-1:0] STOP_CNT_ZERO = 4'h0;
  localparam logic [STOP_CNT_W-1:0] STOP_CNT_ONE  = 4'h1;

  // ==========================================================================
  // Host controller states
  typedef enum logic [1:0] {
    H_RUN    = 2'b00,
    H_NEGATE = 2'b01,
    H_WATCH  = 2'b11,
    H_STOP   = 2'b10
  } host_state_t;

endpackage : clkrun_pkg

// ===== hdl/clkrun_if.sv
// Open-drain clock run line shared by host controller and keeper.
// The interface itself resolves the wire from the two enables.
`timescale 1ns/1ps
`default_nettype none
interface clkrun_if;
  // Host end
  logic host_out;
  logic host_oe_n;
  // Keeper end
  logic keep_out;
  logic keep_oe_n;
  // Resolved line level, pulled up at the host
  logic line;

  assign line = (!keep_oe_n && !keep_out) ? 1'b0 :
                (!host_oe_n) ? host_out : 1'b1;

  modport keeper (input line, output keep_out, output keep_oe_n);
  modport host   (input line, output host_out, output host_oe_n);
endinterface : clkrun_if
`default_nettype wire

// ===== hdl/clkrun_sync.sv
// Two flip-flop synchroniser for the keeper enable pin.
// Assumes the pin is asynchronous to CLOCK.
`timescale 1ns/1ps
`default_nettype none
module clkrun_sync (
  // Clock and control
  input  wire  logic clk,
  input  wire  logic rst_n,
  input  wire  logic ce,
  // Data
  input  wire  logic d,
  output var   logic q
);
  logic meta_ff;
  logic nxt_meta;
  logic nxt_q;

  always_comb begin
    nxt_meta = ce ? d : meta_ff;
    nxt_q    = ce ? meta_ff : q;
  end

  // Reset low, matching the pulled-down enable pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q       <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      q       <= nxt_q;
    end
  end
endmodule : clkrun_sync
`default_nettype wire

// ===== hdl/clkrun_keeper.sv
// Clock run keeper: reasserts the line after a host negation.
// Assumes the line moves on CLOCK; only the enable pin is synchronised.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RQ1 - Host keeps clock running while port works
// RQ2 - Two stage shift register fed by line
// RQ3 - Keeper only pulls low, never drives high
// RQ4 - Disabled after reset, enable pin low
// RQ5 - Enable high starts monitoring every clock
// RQ6 - Enable low forces pull-down off
// RQ7 - Asserted line sampled keeps driver off
// RQ8 - Host negates one clock then releases
// RQ9 - Two negated samples turn pull-down on
// RQ10 - Pull-down held two clocks then released
// RQ11 - Host reasserts line within the hold
// RQ12 - Disabled keeper lets host stop clock
// RQ13 - Serial interrupts reach host without clock
// RQ14 - Stages reset to asserted sample value
module clkrun_keeper
  import clkrun_pkg::*;
(
  // Clock and reset
  input  wire  logic CLOCK,
  input  wire  logic RST_N,
  input  wire  logic CE,
  // Driver controlled enable
  input  wire  logic KEEPER_ENABLE_PIN,
  // Serial port interrupt, clock independent
  input  wire  logic UART_IRQ,
  output logic       IRQ_TO_HOST,
  // Status
  output logic       KEEPING,
  // Line
  clkrun_if.keeper   LINK
);
  import clkrun_pkg::*;

  // ==========================================================================
  // Input capture
  logic line_s;
  logic en_s;

  // Same clock as the host end, so the line is read without a
  // synchroniser; one would stretch the two clock answer [RQ9]
  assign line_s = LINK.line;

  // Enable pin floats low after reset, so the sync resets to zero [RQ4]
  clkrun_sync u_en_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .ce    (CE),
    .d     (KEEPER_ENABLE_PIN),
    .q     (en_s)
  );

  // ==========================================================================
  // Two stage shift register
  logic [KEEP_STAGES-1:0] stage_ff;
  logic [KEEP_STAGES-1:0] nxt_stage;
  logic [KEEP_STAGES-1:0] shift_in;

  // Stage zero takes the line, every later stage its neighbour [RQ2]
  assign shift_in[0] = line_s;
  for (genvar gi = 1; gi < KEEP_STAGES; gi++) begin : g_shift
    assign shift_in[gi] = stage_ff[gi-1];
  end

  always_comb begin
    nxt_stage = stage_ff;
    if (CE) begin
      if (en_s) begin
        nxt_stage = shift_in; // [RQ5]
      end else begin
        // Disabled keeper forgets what it saw, so enabling is quiet [RQ6]
        nxt_stage = {KEEP_STAGES{LINE_ASSERTED}};
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      stage_ff <= {KEEP_STAGES{LINE_ASSERTED}}; // [RQ14]
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // ==========================================================================
  // Pull-down control
  logic drive_ff;
  logic nxt_drive;
  logic start_pull;
  logic hold_pull;

  // True when every stage holds the given line level
  function automatic logic stages_at(
    input logic [KEEP_STAGES-1:0] stages,
    input logic                   level
  );
    stages_at = (stages == {KEEP_STAGES{level}});
  endfunction : stages_at

  always_comb begin
    nxt_drive  = drive_ff;
    start_pull = 1'b0;
    hold_pull  = 1'b0;
    if (CE) begin
      // Only all-negated samples start a pull [RQ7]
      start_pull = stages_at(nxt_stage, LINE_NEGATED); // [RQ9]
      // Held until the asserted level reaches the last stage [RQ10]
      hold_pull  = drive_ff && (nxt_stage[KEEP_STAGES-1] == LINE_NEGATED);
      // Disabled keeper never pulls [RQ6] [RQ12]
      nxt_drive  = en_s && (start_pull || hold_pull);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  // ==========================================================================
  // Open-drain driver: data fixed low, enable does the work [RQ3]
  assign LINK.keep_out  = LINE_ASSERTED;
  assign LINK.keep_oe_n = drive_ff ? OE_DRIVE : OE_RELEASE;
  assign KEEPING        = drive_ff;

  // Passed combinationally so it needs no bus clock [RQ13]
  assign IRQ_TO_HOST = UART_IRQ;

endmodule : clkrun_keeper
`default_nettype wire

// ===== hdl/clkrun_host.sv
// Host controller end of the clock run line.
// Assumes stop requests come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module clkrun_host
  import clkrun_pkg::*;
(
  // Clock and reset
  input  wire  logic CLOCK,
  input  wire  logic RST_N,
  input  wire  logic CE,
  // User side
  input  wire  logic STOP_REQ,
  input  wire  logic WAKE_REQ,
  output logic       CLK_RUNNING,
  output logic       STOP_DENIED,
  // Line
  clkrun_if.host     LINK
);
  import clkrun_pkg::*;

  logic            line_s;
  host_state_t     state_ff;
  host_state_t     nxt_state;
  logic [STOP_CNT_W-1:0] cnt_ff;
  logic [STOP_CNT_W-1:0] nxt_cnt;
  logic            denied_ff;
  logic            nxt_denied;

  // Same clock as the keeper; a synchroniser would miss its hold [RQ11]
  assign line_s = LINK.line;

  // ==========================================================================
  // Stop negotiation
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_denied = 1'b0;
    if (CE) begin
      unique case (state_ff)
        H_RUN: if (STOP_REQ) begin
          nxt_state = H_NEGATE;
        end
        // One clock of high drive, then release [RQ8]
        H_NEGATE: begin
          nxt_state = H_WATCH;
          nxt_cnt   = STOP_CNT_W'(STOP_WAIT_CYC);
        end
        H_WATCH: begin
          if (line_s == LINE_ASSERTED) begin
            nxt_state  = H_RUN; // Target reasserted [RQ11]
            nxt_denied = 1'b1;
          end else if (cnt_ff == STOP_CNT_ONE) begin
            nxt_state = H_STOP; // [RQ12]
          end else begin
            nxt_cnt = cnt_ff - STOP_CNT_ONE;
          end
        end
        // Interrupt restarts the clock [RQ13]
        H_STOP: if (WAKE_REQ) begin
          nxt_state = H_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_ff  <= H_RUN;
      cnt_ff    <= STOP_CNT_ZERO;
      denied_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      denied_ff <= nxt_denied;
    end
  end

  // Host holds asserted while running, so the clock stays on [RQ1]
  assign LINK.host_out  = (state_ff == H_NEGATE) ? LINE_NEGATED : LINE_ASSERTED;
  assign LINK.host_oe_n = (state_ff == H_RUN || state_ff == H_NEGATE) ? OE_DRIVE : OE_RELEASE;
  assign CLK_RUNNING    = (state_ff != H_STOP);
  assign STOP_DENIED    = denied_ff;

endmodule : clkrun_host
`default_nettype wire

// ===== dv/clkrun_keeper_props.sv
// Checker on the clock run line between host end and keeper.
// Assumes one clock domain and the line signals of the shared interface.
`timescale 1ns/1ps
`default_nettype none
module clkrun_keeper_props (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Line
  input wire logic host_out,
  input wire logic host_oe_n,
  input wire logic keep_out,
  input wire logic keep_oe_n,
  input wire logic line
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // ==========================================================================
  // Keeper
  a_keep_only_low: assert property (!keep_oe_n |-> !keep_out)
    else $error("keeper drives line high");
  a_pull_after_two: assert property ($fell(keep_oe_n) |-> $past(line, 1) && $past(line, 2))
    else $error("pull without two negated samples");
  a_pull_hold_time: assert property ($fell(keep_oe_n) |-> !keep_oe_n[*2] ##[1:6] keep_oe_n)
    else $error("pull not held two clocks or never released");
  a_asserted_quiet: assert property ((!host_oe_n && !host_out)[*6] |-> keep_oe_n)
    else $error("keeper pulls while host asserts");
  a_idle_after_reset: assert property ($rose(RST_N) |-> keep_oe_n[*3])
    else $error("keeper pulls right after reset");
  // ==========================================================================
  // Host end
  a_host_one_clock: assert property (!host_oe_n && host_out |=> host_oe_n)
    else $error("host drives negation over one clock");
  a_host_answers: assert property ($fell(keep_oe_n) |-> ##[1:6] (!host_oe_n && !host_out))
    else $error("host does not reassert line");
  a_line_kept_low: assert property ($rose(keep_oe_n) |-> !line)
    else $error("line high when keeper releases");
  c_pull: cover property ($fell(keep_oe_n));
  c_negate: cover property (!host_oe_n && host_out);
  c_stopped: cover property (line[*8]);
endmodule : clkrun_keeper_props
`default_nettype wire

// ===== dv/clock_run_keeper_tb.sv
// Testbench joining host end and keeper through the line interface.
// Assumes the design package and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module clock_run_keeper_tb;
  import clkrun_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, en = 1'b0, irq = 1'b0;
  logic stop = 1'b0, wake = 1'b0, irq_out, keeping, running, denied, pulled, den, kept;
  int error_cnt = 0, n_compared = 0, cyc = 0, pull_cyc = 0, first_pull = 0;
  clkrun_if link ();
  always #12.5 clk = ~clk;
  clkrun_keeper clkrun_keeper_i (.CLOCK(clk), .RST_N(rst_n), .CE(ce),
    .KEEPER_ENABLE_PIN(en), .UART_IRQ(irq), .IRQ_TO_HOST(irq_out),
    .KEEPING(keeping), .LINK(link.keeper));
  clkrun_host clkrun_host_i (.CLOCK(clk), .RST_N(rst_n), .CE(ce), .STOP_REQ(stop),
    .WAKE_REQ(wake), .CLK_RUNNING(running), .STOP_DENIED(denied), .LINK(link.host));
  clkrun_keeper_props clkrun_keeper_props_i (.CLOCK(clk), .RST_N(rst_n),
    .host_out(link.host_out), .host_oe_n(link.host_oe_n), .keep_out(link.keep_out),
    .keep_oe_n(link.keep_oe_n), .line(link.line));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // One stop request, then watch the line for twenty clocks
  task automatic request_stop;
    pulled = 1'b0;
    den = 1'b0;
    kept = 1'b0;
    pull_cyc = 0;
    first_pull = 0;
    @(negedge clk) stop = 1'b1;
    @(negedge clk) stop = 1'b0;
    for (int i = 1; i <= 20; i++) begin
      @(negedge clk);
      if (!link.keep_oe_n && first_pull == 0) begin
        first_pull = i;
      end
      if (!link.keep_oe_n) begin
        pull_cyc++;
      end
      pulled = pulled | !link.keep_oe_n;
      kept = kept | keeping;
      den = den | denied;
    end
  endtask : request_stop
  // ==========================================================================
  // Scenarios
  task automatic t_disabled;
    @(negedge clk) en = 1'b0;
    repeat (4) @(negedge clk);
    request_stop();
    chk("pull", pulled, 1'b0);
    chk("keeping", kept, 1'b0);
    chk("denied", den, 1'b0);
    chk("running", running, 1'b0);
    @(negedge clk) wake = 1'b1;
    @(negedge clk) wake = 1'b0;
    repeat (10) @(negedge clk);
    chk("running", running, 1'b1);
    chk("line", link.line, LINE_ASSERTED);
  endtask : t_disabled
  task automatic t_enabled;
    @(negedge clk) en = 1'b1;
    repeat (10) @(negedge clk);
    chk("idle oe", link.keep_oe_n, OE_RELEASE);
    request_stop();
    chk("pull", pulled, 1'b1);
    chk("keeping", kept, 1'b1);
    chk("pull start", first_pull, KEEP_STAGES);
    chk("pull length", pull_cyc, KEEP_STAGES);
    chk("denied", den, 1'b1);
    chk("running", running, 1'b1);
    chk("oe after", link.keep_oe_n, OE_RELEASE);
    chk("line", link.line, LINE_ASSERTED);
  endtask : t_enabled
  task automatic t_irq;
    @(negedge clk) ce = 1'b0;
    irq = 1'b1;
    #1 chk("irq", irq_out, 1'b1);
    @(negedge clk) irq = 1'b0;
    #1 chk("irq", irq_out, 1'b0);
    @(negedge clk) ce = 1'b1;
  endtask : t_irq
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("oe reset", link.keep_oe_n, OE_RELEASE);
    chk("line reset", link.line, LINE_ASSERTED);
    t_disabled();
    t_enabled();
    t_disabled();
    t_irq();
    finish_test();
  end
endmodule : clock_run_keeper_tb
`default_nettype wire
